// ==== bench/rww_core_asserts.sv ====
// Checker for the remote wake core, watching only its ports.
// Assumes one clock domain and a zero-wait APB slave.
module rww_core_chk
   import rww_pkg::*;
(
   // Clock and reset
   input wire logic              sys_clk,
   input wire logic              reset,
   // APB
   input wire logic              psel,
   input wire logic              penable,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   // USB side
   input wire logic              usb_suspend,
   input wire logic              usb_resume,
   input wire logic              remote_wake,
   input wire logic              suspended
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   property p_pulse; remote_wake |=> !remote_wake; endproperty
   a_pulse: assert property (p_pulse) else $error("remote_wake too long");
   property p_leave; remote_wake |-> !suspended; endproperty
   a_leave: assert property (p_leave) else $error("no return to normal");
   property p_from; remote_wake |-> $past(suspended); endproperty
   a_from: assert property (p_from) else $error("wake while normal");
   property p_enter; !suspended && usb_suspend |=> suspended; endproperty
   a_enter: assert property (p_enter) else $error("suspend not entered");
   property p_resume; suspended && usb_resume |=> !suspended; endproperty
   a_resume: assert property (p_resume) else $error("resume ignored");
   property p_map; psel && penable && paddr <= OFF_INTERRUPT_STATUS_REG && paddr[1:0] == 2'h0 |-> !pslverr;
   endproperty
   a_map: assert property (p_map) else $error("error on mapped word");
   property p_err; pslverr |-> psel && penable; endproperty
   a_err: assert property (p_err) else $error("error outside access");
   property p_hold; psel && penable |=> $stable(prdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_ready; psel && penable |-> pready; endproperty
   a_ready: assert property (p_ready) else $error("access not answered");
endmodule
bind rww_core rww_core_chk rww_core_chk_inst (.sys_clk, .reset, .psel, .penable, .paddr,
   .prdata, .pready, .pslverr, .usb_suspend, .usb_resume, .remote_wake, .suspended);

// ==== bench/rww_core_test.sv ====
// Self-checking bench for the remote wake core.
// Assumes the host model for APB and the bound checker.
module rww_core_test
   import rww_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, rd_err, phy_interrupt;
   logic mac_good_frame, usb_suspend, usb_resume, remote_wake, wake_interrupt, suspended;
   logic phy_link_up;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, rd_data;
   logic [4:0]        mac_hit;
   logic [PIN_N-1:0]  gpio_pin;
   int fail_count = 0, checks_done = 0, cyc = 0;
   initial
   begin
      sys_clk = 1'h0;
      forever #4 sys_clk = ~sys_clk;
   end
   rww_core rww_core_inst (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .mac_unicast_hit(mac_hit[0]), .mac_magic_hit(mac_hit[1]),
      .mac_frame_hit(mac_hit[2]), .mac_perfect_hit(mac_hit[3]),
      .mac_broadcast_hit(mac_hit[4]), .mac_good_frame, .phy_interrupt,
      .phy_link_up, .gpio_pin, .usb_suspend, .usb_resume, .remote_wake,
      .wake_interrupt, .suspended);
   rww_host rww_host_inst (.sys_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr);
   // Run should end before 5000 cycles
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         fail_count++;
         results();
      end
   end
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] e);
      checks_done++;
      if (s !== e)
      begin
         fail_count++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      rww_host_inst.xfer(1'h1, a, d, rd_data, rd_err);
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      rww_host_inst.xfer(1'h0, a, 32'h0, rd_data, rd_err);
      chk(rd_data, e);
   endtask
   // Looks for a wake pulse within 20 cycles
   task automatic wk(input logic e);
      logic s;
      s = 1'h0;
      for (int n = 0; n < 20 && !s; n++)
      begin
         @(posedge sys_clk);
         #1 s = remote_wake;
      end
      chk({31'h0, s}, {31'h0, e});
   endtask
   task automatic susp(input logic [DATA_W-1:0] pmt);
      wr(OFF_PMT, pmt);
      @(posedge sys_clk) usb_suspend <= 1'h1;
      @(posedge sys_clk) usb_suspend <= 1'h0;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_lan;
      wr(OFF_MAC_WAKE, 32'h02);
      wr(OFF_PMT, 32'h0C);
      susp(32'h02);
      @(posedge sys_clk) mac_hit <= 5'h1D;
      wk(1'h0);
      @(posedge sys_clk) mac_hit <= 5'h1F;
      wk(1'h1);
      chk({31'h0, wake_interrupt}, 32'h1);
      wr(OFF_PMT, 32'h0A);
      rd(OFF_PMT, 32'h0A);
      @(posedge sys_clk) mac_hit <= '0;
      wr(OFF_PMT, 32'h0A);
      rd(OFF_PMT, 32'h02);
      rd(OFF_MAC_WAKE, 32'h42);
      wr(OFF_MAC_WAKE, 32'h40);
      wr(OFF_PMT, 32'h00);
      $display("lan test done");
   endtask
   task automatic t_energy;
      wr(OFF_PMT, 32'h0C);
      susp(32'h01);
      @(posedge sys_clk) phy_interrupt <= 1'h1;
      wk(1'h0);
      chk({31'h0, suspended}, 32'h1);
      @(posedge sys_clk) usb_resume <= 1'h1;
      @(posedge sys_clk) usb_resume <= 1'h0;
      wr(OFF_PMT, 32'h05);
      rd(OFF_PMT, 32'h05);
      @(posedge sys_clk) phy_interrupt <= 1'h0;
      wr(OFF_PMT, 32'h05);
      rd(OFF_PMT, 32'h01);
      susp(32'h11);
      @(posedge sys_clk) phy_interrupt <= 1'h1;
      wk(1'h1);
      @(posedge sys_clk) phy_interrupt <= 1'h0;
      wr(OFF_PMT, 32'h04);
      $display("energy test done");
   endtask
   task automatic t_good;
      wr(OFF_PMT, 32'h0C);
      susp(32'h30);
      @(posedge sys_clk) mac_good_frame <= 1'h1;
      @(posedge sys_clk) mac_good_frame <= 1'h0;
      wk(1'h1);
      rd(OFF_PMT, 32'h38);
      wr(OFF_PMT, 32'h08);
      $display("good frame test done");
   endtask
   // Pin 7 level 0 with polarity 0 would be active, so a set bit means the pin leaked
   task automatic t_link;
      wr(OFF_PIN_CFG, 32'h77);
      wr(OFF_PIN_WAKE, 32'h8000_0080);
      rd(OFF_INTERRUPT_STATUS_REG, 32'h0);
      susp(32'h20);
      @(posedge sys_clk) phy_link_up <= 1'h1;
      wk(1'h0);
      wr(OFF_PMT, 32'h00);
      wk(1'h1);
      rd(OFF_INTERRUPT_STATUS_REG, 32'h80);
      @(posedge sys_clk) phy_link_up <= 1'h0;
      wr(OFF_INTERRUPT_STATUS_REG, 32'h80);
      rd(OFF_INTERRUPT_STATUS_REG, 32'h0);
      $display("link test done");
   endtask
   task automatic t_pins;
      rd(OFF_PIN_CFG, 32'hFF);
      rd(8'h20, 32'h0);
      chk({31'h0, rd_err}, 32'h1);
      wr(OFF_PIN_WAKE, 32'h0208_0208);
      susp(32'h20);
      @(posedge sys_clk) gpio_pin[3] <= 1'h1;
      wk(1'h0);
      @(posedge sys_clk) gpio_pin[9] <= 1'h1;
      wk(1'h1);
      rd(OFF_INTERRUPT_STATUS_REG, 32'h200);
      wr(OFF_PIN_CFG, 32'hF7);
      wk(1'h0);
      rd(OFF_INTERRUPT_STATUS_REG, 32'h208);
      @(posedge sys_clk) gpio_pin <= '0;
      repeat (5) @(posedge sys_clk);
      wr(OFF_INTERRUPT_STATUS_REG, 32'h208);
      rd(OFF_INTERRUPT_STATUS_REG, 32'h0);
      $display("pin test done");
   endtask
   initial
   begin
      reset = 1'h1;
      mac_hit = '0;
      mac_good_frame = 1'h0;
      phy_interrupt = 1'h0;
      phy_link_up = 1'h0;
      gpio_pin = '0;
      usb_suspend = 1'h0;
      usb_resume = 1'h0;
      repeat (16) @(posedge sys_clk);
      reset <= 1'h0;
      t_pins();
      t_lan();
      t_energy();
      t_good();
      t_link();
      results();
   end
endmodule

// ==== bench/rww_host.sv ====
// APB host model standing in for the driver.
// Assumes an APB slave on sys_clk; waits end only by the bench timeout.
module rww_host
   import rww_pkg::*;
(
   // Clock
   input  wire logic              sys_clk,
   // APB master
   output logic                   psel,
   output logic                   penable,
   output logic                   pwrite,
   output logic      [ADDR_W-1:0] paddr,
   output logic      [DATA_W-1:0] pwdata,
   input  wire logic [DATA_W-1:0] prdata,
   input  wire logic              pready,
   input  wire logic              pslverr
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      psel = 1'h0;
      penable = 1'h0;
   end
   task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] r, output logic e);
      @(posedge sys_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'h1;
      do @(posedge sys_clk); while (pready !== 1'h1);
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
endmodule

// ==== rtl/rww_core.sv ====
// Remote wake logic: APB registers, wake status, suspend state, remote_wake.
// Assumes MAC and PHY indications come from logic on sys_clk; pins are async.
module rww_core
   import rww_pkg::*;
(
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              reset,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [DATA_W-1:0] pwdata,
   output logic      [DATA_W-1:0] prdata,
   output logic                   pready,
   output logic                   pslverr,
   // MAC wake detections
   input  wire logic              mac_unicast_hit,
   input  wire logic              mac_magic_hit,
   input  wire logic              mac_frame_hit,
   input  wire logic              mac_perfect_hit,
   input  wire logic              mac_broadcast_hit,
   input  wire logic              mac_good_frame,
   // PHY indications
   input  wire logic              phy_interrupt,
   input  wire logic              phy_link_up,
   // General-purpose pins
   input  wire logic [PIN_N-1:0]  gpio_pin,
   // USB device side
   input  wire logic              usb_suspend,
   input  wire logic              usb_resume,
   output logic                   remote_wake,
   output logic                   wake_interrupt,
   output logic                   suspended
);

   // ****************************************
   // Registers and state
   // ****************************************
   logic [MAC_EVT_N-1:0]    mac_wake_enable;
   logic [RECV_N-1:0]       received;
   logic                    energy_detect_enable;
   logic                    lan_wake_enable;
   logic [1:0]              wakeup_status_bits;
   logic [1:0]              suspend_mode;
   logic [LOW_PIN_N-1:0]    pin_wake_gate;
   logic [2*HIGH_PIN_N-1:0] pin_function_select;
   logic [HIGH_PIN_N-1:0]   pin_direction;
   logic [PIN_N-1:0]        pin_wake_enable;
   logic [PIN_N-1:0]        pin_wake_polarity;
   logic                    link_up_wake_enable;
   logic [PIN_N-1:0]        pin_interrupt_status;
   rww_state_t              state;
   rww_state_t              next_state;

   // ****************************************
   // Bus decode
   // ****************************************
   logic             setup_phase;
   logic             access_phase;
   logic             wr_en;
   logic             hit_mac;
   logic             hit_pmt;
   logic             hit_cfg;
   logic             hit_wake;
   logic             hit_int;
   logic             mapped;
   logic [DATA_W-1:0] next_prdata;

   assign setup_phase  = psel & ~penable;
   assign access_phase = psel & penable;
   assign hit_mac  = (paddr == OFF_MAC_WAKE);
   assign hit_pmt  = (paddr == OFF_PMT);
   assign hit_cfg  = (paddr == OFF_PIN_CFG);
   assign hit_wake = (paddr == OFF_PIN_WAKE);
   assign hit_int  = (paddr == OFF_INTERRUPT_STATUS_REG);
   assign mapped   = hit_mac | hit_pmt | hit_cfg | hit_wake | hit_int;
   assign wr_en    = access_phase & pwrite & mapped;

   // Read data is captured in the setup cycle, so zero wait states still give
   // a flopped prdata.
   assign pready  = 1'b1;
   assign pslverr = access_phase & ~mapped;

   always_comb
   begin
      next_prdata = ZERO_WORD;
      if (hit_mac)
      begin
         next_prdata[MW_EN_LSB +: MAC_EVT_N] = mac_wake_enable;
         next_prdata[MW_RECV_LSB +: RECV_N]  = received;
      end
      else if (hit_pmt)
      begin
         next_prdata[PMT_ED_BIT]          = energy_detect_enable;
         next_prdata[PMT_LAN_BIT]         = lan_wake_enable;
         next_prdata[PMT_WAKEUP_STATUS_BITS_LSB +: 2]   = wakeup_status_bits;
         next_prdata[PMT_MODE_LSB +: 2]   = suspend_mode;
         next_prdata[PMT_SUSP_BIT]        = (state == st_suspended);
      end
      else if (hit_cfg)
      begin
         next_prdata[CFG_GATE_LSB +: LOW_PIN_N]    = pin_wake_gate;
         next_prdata[CFG_FUNC_LSB +: 2*HIGH_PIN_N] = pin_function_select;
         next_prdata[CFG_DIR_LSB +: HIGH_PIN_N]    = pin_direction;
      end
      else if (hit_wake)
      begin
         next_prdata[WK_EN_LSB +: PIN_N]  = pin_wake_enable;
         next_prdata[WK_POL_LSB +: PIN_N] = pin_wake_polarity;
         next_prdata[WK_LINK_BIT]         = link_up_wake_enable;
      end
      else if (hit_int)
      begin
         next_prdata[INT_PIN_LSB +: PIN_N] = pin_interrupt_status;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
         prdata <= ZERO_WORD;
      else if (setup_phase)
         prdata <= next_prdata;
   end

   // ****************************************
   // Configuration registers
   // ****************************************
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         mac_wake_enable      <= '0;
         energy_detect_enable <= 1'b0;
         lan_wake_enable      <= 1'b0;
         suspend_mode         <= MODE_ZERO;
      end
      else
      begin
         if (wr_en && hit_mac)
            mac_wake_enable <= pwdata[MW_EN_LSB +: MAC_EVT_N];
         if (wr_en && hit_pmt)
         begin
            energy_detect_enable <= pwdata[PMT_ED_BIT];
            lan_wake_enable      <= pwdata[PMT_LAN_BIT];
            suspend_mode         <= pwdata[PMT_MODE_LSB +: 2];
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         pin_wake_gate       <= GATE_RST;
         pin_function_select <= '0;
         pin_direction       <= '0;
         pin_wake_enable     <= '0;
         pin_wake_polarity   <= '0;
         link_up_wake_enable <= 1'b0;
      end
      else
      begin
         if (wr_en && hit_cfg)
         begin
            pin_wake_gate       <= pwdata[CFG_GATE_LSB +: LOW_PIN_N];
            pin_function_select <= pwdata[CFG_FUNC_LSB +: 2*HIGH_PIN_N];
            pin_direction       <= pwdata[CFG_DIR_LSB +: HIGH_PIN_N];
         end
         if (wr_en && hit_wake)
         begin
            pin_wake_enable     <= pwdata[WK_EN_LSB +: PIN_N];
            pin_wake_polarity   <= pwdata[WK_POL_LSB +: PIN_N];
            link_up_wake_enable <= pwdata[WK_LINK_BIT];
         end
      end
   end

   // ****************************************
   // MAC and PHY wake events
   // ****************************************
   logic [MAC_EVT_N-1:0] mac_hits;
   logic                 mac_composite;
   logic                 any_mac_enable;
   logic                 good_frame_evt;
   logic                 lan_evt;
   logic                 energy_evt;
   logic [RECV_N-1:0]    recv_set;
   logic [RECV_N-1:0]    recv_clr;
   logic [1:0]           wakeup_status_bits_set;
   logic [1:0]           wakeup_status_bits_clr;

   assign mac_hits[EVT_UNICAST] = mac_unicast_hit;
   assign mac_hits[EVT_MAGIC]   = mac_magic_hit;
   assign mac_hits[EVT_FRAME]   = mac_frame_hit;
   assign mac_hits[EVT_PERFECT] = mac_perfect_hit;
   assign mac_hits[EVT_BCAST]   = mac_broadcast_hit;

   assign mac_composite  = |(mac_hits & mac_wake_enable);
   assign any_mac_enable = |mac_wake_enable;
   // Good frames only count when every MAC event is disabled
   assign good_frame_evt = mac_good_frame & ~any_mac_enable;
   assign lan_evt        = (mac_composite & lan_wake_enable) | good_frame_evt;
   // PHY raises phy_interrupt on line activity while in energy power-down
   assign energy_evt     = phy_interrupt & energy_detect_enable;

   assign recv_set[RCV_FRAME]   = mac_frame_hit & mac_wake_enable[EVT_FRAME];
   assign recv_set[RCV_MAGIC]   = mac_magic_hit & mac_wake_enable[EVT_MAGIC];
   assign recv_set[RCV_PERFECT] = mac_perfect_hit & mac_wake_enable[EVT_PERFECT];
   assign recv_set[RCV_BCAST]   = mac_broadcast_hit & mac_wake_enable[EVT_BCAST];
   assign recv_clr = (wr_en && hit_mac) ? pwdata[MW_RECV_LSB +: RECV_N] : '0;

   // Write-one-to-clear, refused while the source is still asserted
   assign wakeup_status_bits_set[WAKEUP_STATUS_BITS_LAN] = lan_evt;
   assign wakeup_status_bits_set[WAKEUP_STATUS_BITS_ED]  = energy_evt;
   assign wakeup_status_bits_clr[WAKEUP_STATUS_BITS_LAN] = wr_en && hit_pmt && pwdata[PMT_WAKEUP_STATUS_BITS_LSB + WAKEUP_STATUS_BITS_LAN]
                               && !mac_composite;
   assign wakeup_status_bits_clr[WAKEUP_STATUS_BITS_ED]  = wr_en && hit_pmt && pwdata[PMT_WAKEUP_STATUS_BITS_LSB + WAKEUP_STATUS_BITS_ED]
                               && !phy_interrupt;

   // Set wins over a clear in the same cycle
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         wakeup_status_bits <= '0;
      else
         wakeup_status_bits <= (wakeup_status_bits & ~wakeup_status_bits_clr) | wakeup_status_bits_set;
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
         received <= '0;
      else
         received <= (received & ~recv_clr) | recv_set;
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
         wake_interrupt <= 1'b0;
      else
         wake_interrupt <= lan_evt | energy_evt;
   end

   // ****************************************
   // Pin wake
   // ****************************************
   logic [PIN_N-1:0] pin_level;
   logic [PIN_N-1:0] pin_clr;

   rww_pin_if pin_bus ();

   rww_pin_sync #(
      .W (PIN_N)
   ) u_sync (
      .sys_clk   (sys_clk),
      .reset     (reset),
      .pin_raw   (gpio_pin),
      .pin_level (pin_level)
   );

   assign pin_bus.gate       = pin_wake_gate;
   assign pin_bus.func       = pin_function_select;
   assign pin_bus.dir        = pin_direction;
   assign pin_bus.wake_en    = pin_wake_enable;
   assign pin_bus.polarity   = pin_wake_polarity;
   assign pin_bus.link_up_en = link_up_wake_enable;
   assign pin_bus.link_up    = phy_link_up;
   assign pin_bus.level      = pin_level;

   rww_pin_wake u_pin_wake (
      .pins (pin_bus.wake)
   );

   assign pin_clr = (wr_en && hit_int) ? pwdata[INT_PIN_LSB +: PIN_N] : '0;

   // A level that stays active keeps its status set, so it cannot be cleared
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         pin_interrupt_status <= '0;
      else
         pin_interrupt_status <= (pin_interrupt_status & ~pin_clr) | pin_bus.hit;
   end

   // ****************************************
   // Suspend state and remote wake
   // ****************************************
   logic             mode_zero;
   logic             mode_one;
   logic             mode_three;
   logic [PIN_N-1:0] plain_pin_mask;
   logic             lan_req;
   logic             good_req;
   logic             energy_req;
   logic             pin_req;
   logic             link_req;
   logic             wake_req;

   assign mode_zero  = (suspend_mode == MODE_ZERO);
   assign mode_one   = (suspend_mode == MODE_ONE);
   assign mode_three = (suspend_mode == MODE_THREE);

   // A status bit left set wakes at once, which is why the host clears it first
   assign lan_req    = mode_zero & wakeup_status_bits[WAKEUP_STATUS_BITS_LAN]
                       & lan_wake_enable & any_mac_enable;
   assign good_req   = mode_three & wakeup_status_bits[WAKEUP_STATUS_BITS_LAN]
                       & ~any_mac_enable;
   assign energy_req = mode_one & wakeup_status_bits[WAKEUP_STATUS_BITS_ED]
                       & energy_detect_enable;

   // Pin 7 in link-up use only wakes from states zero and three
   always_comb
   begin
      plain_pin_mask = '1;
      plain_pin_mask[LINK_PIN] = ~link_up_wake_enable;
   end
   assign pin_req  = |(pin_interrupt_status & plain_pin_mask);
   assign link_req = pin_interrupt_status[LINK_PIN] & link_up_wake_enable
                     & (mode_zero | mode_three);
   assign wake_req = lan_req | good_req | energy_req | pin_req | link_req;

   always_comb
   begin
      next_state = state;
      unique case (state)
         st_normal:
         begin
            if (usb_suspend)
               next_state = st_suspended;
         end
         st_suspended:
         begin
            if (wake_req || usb_resume)
               next_state = st_normal;
         end
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
         state <= st_normal;
      else
         state <= next_state;
   end

   // Normal state never signals, whatever the status bits hold
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         remote_wake <= 1'b0;
      else
         remote_wake <= (state == st_suspended) && wake_req;
   end

   assign suspended = (state == st_suspended);

endmodule

// ==== rtl/rww_pin_sync.sv ====
// Three-stage synchroniser for asynchronous pin levels.
// Assumes pins are quasi-static; a change counts once stages two and three agree.
module rww_pin_sync
   import rww_pkg::*;
#(
   parameter int W = PIN_N
)
(
   // Clock and reset
   input  wire logic         sys_clk,
   input  wire logic         reset,
   // Pins and clean levels
   input  wire logic [W-1:0] pin_raw,
   output logic      [W-1:0] pin_level
);

   logic [W-1:0] stage1;
   logic [W-1:0] stage2;
   logic [W-1:0] stage3;

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end
      else
      begin
         stage1 <= pin_raw;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // Holds while the two late stages disagree
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         pin_level <= '0;
      else
         pin_level <= (stage2 & stage3) | (pin_level & (stage2 ^ stage3));
   end

endmodule

// ==== rtl/rww_pin_wake.sv ====
// Per-pin wake qualification for the eleven general-purpose pins.
// Assumes levels are already synchronised to the core clock.
module rww_pin_wake
   import rww_pkg::*;
(
   // Configuration and result
   rww_pin_if.wake pins
);

   genvar i;
   generate
      for (i = 0; i < PIN_N; i = i + 1)
      begin : g_pin
         logic enabled;
         logic active;
         if (i < LOW_PIN_N)
         begin : g_low
            assign enabled = ~pins.gate[i];
         end
         else
         begin : g_high
            assign enabled = (pins.func[2*(i-LOW_PIN_N) +: 2] == FUNC_GPIO) &&
                             (pins.dir[i-LOW_PIN_N] == DIR_INPUT);
         end
         if (i == LINK_PIN)
         begin : g_link
            // Link-up use ignores the pin and its polarity
            assign active = pins.link_up_en ? pins.link_up
                                            : (pins.level[i] ~^ pins.polarity[i]);
         end
         else
         begin : g_plain
            assign active = pins.level[i] ~^ pins.polarity[i];
         end
         assign pins.hit[i] = enabled & pins.wake_en[i] & active;
      end
   endgenerate

endmodule

// ==== shared/rww_pin_if.sv ====
// Pin wake configuration and result bundle between the core and the pin decoder.
// Assumes both ends run on the core clock.
interface rww_pin_if;
   import rww_pkg::*;
   logic [LOW_PIN_N-1:0]    gate;
   logic [2*HIGH_PIN_N-1:0] func;
   logic [HIGH_PIN_N-1:0]   dir;
   logic [PIN_N-1:0]        wake_en;
   logic [PIN_N-1:0]        polarity;
   logic                    link_up_en;
   logic                    link_up;
   logic [PIN_N-1:0]        level;
   logic [PIN_N-1:0]        hit;

   modport ctrl (output gate, func, dir, wake_en, polarity, link_up_en, link_up, level,
                 input hit);
   modport wake (input gate, func, dir, wake_en, polarity, link_up_en, link_up, level,
                 output hit);
endinterface

// ==== shared/rww_pkg.sv ====
// Constants, field layout and types for the remote wake block.
// Assumes a 32-bit APB slave port and a single 125 MHz core clock.
package rww_pkg;

   // ****************************************
   // Widths
   // ****************************************
   localparam int ADDR_W      = 8;
   localparam int DATA_W      = 32;
   localparam int PIN_N       = 11;
   localparam int LOW_PIN_N   = 8;
   localparam int HIGH_PIN_N  = 3;
   localparam int MAC_EVT_N   = 5;
   localparam int RECV_N      = 4;
   localparam int SYNC_STAGES = 3;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [ADDR_W-1:0] OFF_MAC_WAKE = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_PMT      = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_PIN_CFG  = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_PIN_WAKE = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_INTERRUPT_STATUS_REG  = 8'h10;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int MW_EN_LSB    = 0;
   localparam int MW_RECV_LSB  = 5;
   localparam int PMT_ED_BIT   = 0;
   localparam int PMT_LAN_BIT  = 1;
   localparam int PMT_WAKEUP_STATUS_BITS_LSB = 2;
   localparam int PMT_MODE_LSB = 4;
   localparam int PMT_SUSP_BIT = 6;
   localparam int CFG_GATE_LSB = 0;
   localparam int CFG_FUNC_LSB = 8;
   localparam int CFG_DIR_LSB  = 14;
   localparam int WK_EN_LSB    = 0;
   localparam int WK_POL_LSB   = 16;
   localparam int WK_LINK_BIT  = 31;
   localparam int INT_PIN_LSB  = 0;

   // MAC enable order: unicast, magic, wakeup frame, perfect dest, broadcast
   localparam int EVT_UNICAST = 0;
   localparam int EVT_MAGIC   = 1;
   localparam int EVT_FRAME   = 2;
   localparam int EVT_PERFECT = 3;
   localparam int EVT_BCAST   = 4;
   // Received flag order: wakeup frame, magic, perfect dest, broadcast
   localparam int RCV_FRAME   = 0;
   localparam int RCV_MAGIC   = 1;
   localparam int RCV_PERFECT = 2;
   localparam int RCV_BCAST   = 3;
   localparam int WAKEUP_STATUS_BITS_ED     = 0;
   localparam int WAKEUP_STATUS_BITS_LAN    = 1;
   localparam int LINK_PIN    = 7;

   // ****************************************
   // Codes and reset values
   // ****************************************
   localparam logic [1:0] MODE_ZERO  = 2'h0;
   localparam logic [1:0] MODE_ONE   = 2'h1;
   localparam logic [1:0] MODE_TWO   = 2'h2;
   localparam logic [1:0] MODE_THREE = 2'h3;
   localparam logic [1:0] FUNC_GPIO  = 2'h0;
   localparam logic       DIR_INPUT  = 1'h0;
   localparam logic [LOW_PIN_N-1:0] GATE_RST = 8'hFF;
   localparam logic [DATA_W-1:0]    ZERO_WORD = 32'h0000_0000;

   typedef enum logic [0:0] {st_normal, st_suspended} rww_state_t;

endpackage
